// [rtl/aeo_encoder_out.sv]
// Local design decisions: register access over Avalon-MM and the register offsets.
`default_nettype none
module aeo_encoder_out
   import aeo_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ang_valid,
   input wire logic [ANG_W-1:0] ang_value,
   input wire logic self_test_done,
   input wire logic zcd_valid,
   input wire logic [2:0] zcd_octant,
   input wire logic sl_write,
   input wire logic [5:0] sl_index,
   input wire logic [15:0] sl_data,
   output logic quad_a,
   output logic quad_b,
   output logic quad_index,
   output logic comm_u,
   output logic comm_v,
   output logic comm_w
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   function automatic logic [ANG_W-1:0] neg14(input logic [ANG_W-1:0] x);
      return ANG_W'(0) - x;
   endfunction

   // ---------------- Register bus ----------------
   logic ack_q;
   logic [31:0] rdata_q;
   logic [15:0] cfg_q, aux_q, prot_q;
   logic [15:0] cfg_d, aux_d, prot_d;
   aeo_cfg_t cfg;
   wire bus_req = avs_read | avs_write;
   wire bus_wr = avs_write & ack_q & ce;
   wire [5:0] bus_idx = avs_address[7:2];
   // Bus wins a same-cycle clash; the supply-line write is dropped
   wire sl_ok = sl_write & ~prot_q[SLDIS_BIT] & ce & ~bus_wr;
   wire wr_en = bus_wr | sl_ok;
   wire [5:0] wr_idx = bus_wr ? bus_idx : sl_index;
   wire [15:0] wr_data = bus_wr ? avs_writedata[15:0] : sl_data;
   wire nv_ok = ~prot_q[LOCK_BIT];
   wire cfg_we = wr_en & nv_ok & (wr_idx == CFG_IDX);
   wire aux_we = wr_en & nv_ok & (wr_idx == AUX_IDX);
   wire prot_we = wr_en & nv_ok & (wr_idx == PROT_IDX);
   wire turns_rst = wr_en & (wr_idx == CTRL_IDX) & (wr_data[7:0] == TURNS_RST_CMD);
   wire srw_clr = bus_wr & (bus_idx == WARN_IDX) & avs_writedata[SRW_BIT];

   // A frozen clock enable keeps the master waiting, so no write is lost
   assign avs_waitrequest = bus_req & ~(ack_q & ce);
   assign avs_readdata = rdata_q;
   assign cfg_d = cfg_we ? wr_data : cfg_q;
   assign aux_d = aux_we ? wr_data : aux_q;
   // Lock is sticky until reset so it cannot be undone by either path
   assign prot_d = prot_we ? (wr_data | (prot_q & 16'h0001)) : prot_q;

   assign cfg.res = cfg_q[RES_LSB +: 4];
   assign cfg.idxw = cfg_q[IDXW_LSB +: 2];
   assign cfg.inv = cfg_q[INV_BIT];
   assign cfg.commutation_outputs = cfg_q[UVW_BIT];
   assign cfg.ro = cfg_q[RO_BIT];
   assign cfg.route = cfg_q[ROUTE_BIT];
   assign cfg.slew = aux_q[SLEW_LSB +: 8];
   assign cfg.hyst = aux_q[HYST_LSB +: 6];
   assign cfg.t45 = aux_q[T45_BIT];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
         cfg_q <= CFG_RST;
         aux_q <= AUX_RST;
         prot_q <= PROT_RST;
      end else if (ce) begin
         ack_q <= bus_req & ~ack_q;
         cfg_q <= cfg_d;
         aux_q <= aux_d;
         prot_q <= prot_d;
      end
   end

   // ---------------- Hysteresis ----------------
   logic [ANG_W-1:0] hout_q, raw_q;
   logic head_q, armed_q;
   // Rotation order reverses the sensed direction
   wire [ANG_W-1:0] ang_in = cfg.ro ? neg14(ang_value) : ang_value;
   wire [ANG_W-1:0] hdiff = ang_in - hout_q;
   wire hneg = hdiff[ANG_W-1];
   wire [ANG_W-1:0] hmag = hneg ? neg14(hdiff) : hdiff;
   wire h_fwd = (hdiff != '0) & (head_q ? hneg : ~hneg);
   wire h_back = (head_q ? ~hneg : hneg) & (hmag > {8'h00, cfg.hyst});
   wire [ANG_W-1:0] eff = cfg.route ? hout_q : raw_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hout_q <= '0;
         raw_q <= '0;
         head_q <= 1'b0;
         armed_q <= 1'b0;
      end else if (ce) begin
         if (self_test_done) begin
            head_q <= 1'b0;
            armed_q <= 1'b0;
         end else if (ang_valid) begin
            raw_q <= ang_in;
            armed_q <= 1'b1;
            // First sample places the window behind the angle
            if (!armed_q || h_fwd) begin
               hout_q <= ang_in;
            end else if (h_back) begin
               hout_q <= ang_in;
               head_q <= ~head_q;
            end
         end
      end
   end

   // ---------------- Quadrature with slew limiter ----------------
   logic [ANG_W-1:0] pos_q;
   logic [11:0] tmr_q;
   logic srw_q;
   wire res_ok = (cfg.res >= RES_MIN) & (cfg.res <= RES_MAX);
   wire [3:0] sh = cfg.res - 4'h2;
   wire [ANG_W-1:0] step_lsb = ANG_W'(1) << sh;
   wire [ANG_W-1:0] qmask = ~(step_lsb - ANG_W'(1));
   wire [ANG_W-1:0] tgt = eff & qmask;
   wire [ANG_W-1:0] posm = pos_q & qmask;
   wire [ANG_W-1:0] qd = tgt - posm;
   wire pend = res_ok & (qd != '0);
   wire one_step = (qd == step_lsb) | (qd == neg14(step_lsb));
   wire sl_nz = cfg.slew != 8'h00;
   wire can_step = tmr_q == 12'h000;
   wire delayed = sl_nz & pend & (~one_step | ~can_step);
   wire [ANG_W-1:0] qidx = posm >> sh;
   // Gray sequence 00,01,11,10 from the state count
   wire qa = qidx[1];
   wire qb = qidx[1] ^ qidx[0];
   wire [2:0] idx_states = {1'b0, cfg.idxw} + 3'd1;
   // High over the first states after zero: rise on up, fall on down
   wire qi = posm < (ANG_W'(idx_states) << sh);
   wire [11:0] tmr_load = 12'(cfg.slew * SLEW_TICK_CYC);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pos_q <= '0;
         tmr_q <= '0;
         srw_q <= 1'b0;
      end else if (ce) begin
         srw_q <= delayed | (srw_q & ~srw_clr);
         if (!sl_nz) begin
            if (res_ok) pos_q <= tgt;
            tmr_q <= '0;
         end else if (pend && can_step) begin
            pos_q <= qd[ANG_W-1] ? posm - step_lsb : posm + step_lsb;
            tmr_q <= tmr_load;
         end else if (!can_step) begin
            tmr_q <= tmr_q - 12'h001;
         end
      end
   end

   // ---------------- Commutation ----------------
   wire [4:0] pole_pairs = {1'b0, cfg.res} + 5'd1;
   wire [18:0] elec_full = eff * pole_pairs;
   wire [ANG_W-1:0] elec = elec_full[ANG_W-1:0];
   wire [16:0] sect_full = elec * 3'd6;
   wire [2:0] sect = sect_full[16:14];
   wire cu = sect <= 3'd2;
   wire cv = (sect >= 3'd2) & (sect <= 3'd4);
   wire cw = (sect >= 3'd4) | (sect == 3'd0);

   // ---------------- Turns counter ----------------
   logic [2:0] oct_q;
   logic tarm_q, tw_q;
   logic signed [11:0] cnt_q, cnt_d;
   wire t_up = zcd_valid & tarm_q & (zcd_octant == oct_q + 3'd1)
      & (cfg.t45 | (zcd_octant[1:0] == 2'b00));
   wire t_dn = zcd_valid & tarm_q & (zcd_octant == oct_q - 3'd1)
      & (cfg.t45 | (oct_q[1:0] == 2'b00));
   wire signed [11:0] t_hi = cfg.t45 ? T45_HI : T180_HI;
   wire signed [11:0] t_lo = cfg.t45 ? T45_LO : T180_LO;
   wire sat_up = t_up & (cnt_q >= t_hi);
   wire sat_dn = t_dn & (cnt_q <= t_lo);

   assign cnt_d = turns_rst ? 12'sd0 :
      (sat_up | sat_dn) ? cnt_q :
      t_up ? cnt_q + 12'sd1 :
      t_dn ? cnt_q - 12'sd1 : cnt_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oct_q <= '0;
         tarm_q <= 1'b0;
         tw_q <= 1'b0;
         cnt_q <= '0;
      end else if (ce) begin
         if (zcd_valid) oct_q <= zcd_octant;
         if (zcd_valid) tarm_q <= 1'b1;
         // A saturation in the clearing cycle keeps the flag set
         tw_q <= sat_up | sat_dn | (tw_q & ~turns_rst);
         cnt_q <= cnt_d;
      end
   end

   // ---------------- Outputs and readback ----------------
   logic qa_q, qb_q, qi_q, u_q, v_q, w_q;
   wire [15:0] rd_mux =
      (bus_idx == CFG_IDX) ? cfg_q :
      (bus_idx == AUX_IDX) ? aux_q :
      (bus_idx == PROT_IDX) ? prot_q :
      (bus_idx == HANG_IDX) ? {4'h0, hout_q[ANG_W-1:2]} :
      (bus_idx == WARN_IDX) ? {14'h0000, srw_q, tw_q} :
      (bus_idx == STA_IDX) ? {15'h0000, head_q} :
      (bus_idx == TURNS_IDX) ? {4'h0, cnt_q} : 16'h0000;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
         {qa_q, qb_q, qi_q, u_q, v_q, w_q} <= '0;
      end else if (ce) begin
         if (avs_read && !ack_q) rdata_q <= {16'h0000, rd_mux};
         // Inversion after the mode gate, so idle pins also invert
         {qa_q, qb_q, qi_q} <= ({3{~cfg.commutation_outputs}} & {qa, qb, qi}) ^ {3{cfg.inv}};
         {u_q, v_q, w_q} <= ({3{cfg.commutation_outputs}} & {cu, cv, cw}) ^ {3{cfg.inv}};
      end
   end

   // Pins straight from flops, no gate after the last register
   assign quad_a = qa_q;
   assign quad_b = qb_q;
   assign quad_index = qi_q;
   assign comm_u = u_q;
   assign comm_v = v_q;
   assign comm_w = w_q;

   // ---------------- Checks ----------------
   bus_wait_a:
   assert property ((bus_req && !ack_q && ce) |-> avs_waitrequest ##1 (!ce || !avs_waitrequest))
      else $error("bus answer not one cycle after request");

   quad_gray_a:
   assert property ((ce && sl_nz && res_ok && $stable(cfg_q))
      ##1 (pos_q != $past(pos_q) && $stable(cfg_q))
      |-> $countones({qa, qb} ^ $past({qa, qb})) == 1)
      else $error("quadrature step changed both signals");

   slew_warn_a:
   assert property ((ce && delayed) |=> srw_q)
      else $error("slew delay without warning flag");

   turns_sat_a:
   assert property ((ce && sat_up && !turns_rst) |=> (cnt_q == $past(cnt_q)) && tw_q)
      else $error("turns counter passed its limit or flag not set");

   turns_rst_a:
   assert property ((ce && turns_rst) |=> cnt_q == 12'sd0)
      else $error("turns reset did not zero counter");

   hyst_hold_a:
   assert property ((ce && ang_valid && armed_q && !self_test_done && !h_fwd && !h_back)
      |=> $stable(hout_q) && $stable(head_q))
      else $error("hysteresis output moved inside window");

   head_reset_a:
   assert property ((ce && self_test_done) |=> !head_q && !armed_q)
      else $error("self-test did not clear head direction");

   lock_a:
   assert property ((ce && prot_q[LOCK_BIT])
      |=> $stable(cfg_q) && $stable(aux_q) && prot_q[LOCK_BIT])
      else $error("locked configuration changed");

   index_zero_a:
   assert property ((ce && res_ok && !cfg.commutation_outputs && posm == '0) |=> qi_q == !$past(cfg.inv))
      else $error("index low at zero position");

   comm_six_a:
   assert property ((ce && cfg.commutation_outputs) |=> !((u_q == v_q) && (v_q == w_q)))
      else $error("commutation state outside six-step set");

   sl_off_a:
   assert property ((ce && sl_write && prot_q[SLDIS_BIT] && !bus_wr)
      |=> $stable(cfg_q) && $stable(aux_q) && $stable(prot_q))
      else $error("supply-line write taken while disabled");

   srw_clear_a:
   assert property ((ce && srw_clr && !delayed) |=> !srw_q)
      else $error("slew warning not cleared by write");

   slew_hold_a:
   assert property ((ce && sl_nz && !can_step) |=> $stable(pos_q))
      else $error("quadrature moved before slew interval ended");

   res_freeze_a:
   assert property ((ce && !res_ok) |=> $stable(pos_q))
      else $error("quadrature moved with reserved resolution code");

   quad_follow_a:
   assert property ((ce && !sl_nz && res_ok) |=> pos_q == $past(tgt))
      else $error("quadrature position did not follow angle");

   head_flip_a:
   assert property ((ce && ang_valid && armed_q && !self_test_done && !h_fwd && h_back)
      |=> (head_q != $past(head_q)) && (hout_q == $past(ang_in)))
      else $error("hysteresis exit did not flip head");

   hyst_follow_a:
   assert property ((ce && ang_valid && armed_q && !self_test_done && h_fwd)
      |=> (hout_q == $past(ang_in)) && $stable(head_q))
      else $error("hysteresis output did not follow head");

   turns_up_a:
   assert property ((ce && t_up && !sat_up && !turns_rst)
      |=> cnt_q == $past(cnt_q) + 12'sd1)
      else $error("turns counter missed an up step");

   turns_dn_a:
   assert property ((ce && t_dn && !sat_dn && !turns_rst)
      |=> cnt_q == $past(cnt_q) - 12'sd1)
      else $error("turns counter missed a down step");

   warn_sticky_a:
   assert property ((ce && tw_q && !turns_rst) |=> tw_q)
      else $error("turns warning dropped without reset command");

   hang_read_a:
   assert property ((ce && avs_read && !ack_q && bus_idx == HANG_IDX)
      |=> avs_readdata[11:0] == $past(hout_q[ANG_W-1:2]))
      else $error("hysteresis angle readback wrong");

   head_read_a:
   assert property ((ce && avs_read && !ack_q && bus_idx == STA_IDX)
      |=> avs_readdata[0] == $past(head_q))
      else $error("head direction readback wrong");

   quad_idle_a:
   assert property ((ce && cfg.commutation_outputs)
      |=> {qa_q, qb_q, qi_q} == {3{$past(cfg.inv)}})
      else $error("quadrature pins active in commutation mode");

   slew_step_c: cover property (ce && sl_nz && pend && !one_step && can_step);
   head_flip_c: cover property (ce && ang_valid && armed_q && h_back);
   turns_sat_c: cover property (ce && (sat_up || sat_dn));
   lock_block_c: cover property (bus_wr && prot_q[LOCK_BIT] && bus_idx == CFG_IDX);
   route_hold_c: cover property (ce && cfg.route && ang_valid && armed_q && !h_fwd && !h_back);
endmodule // aeo_encoder_out
`default_nettype wire

// [rtl/aeo_pkg.sv]
`default_nettype none
package aeo_pkg;
   // Register indices; byte address on the bus is four times the index
   localparam logic [5:0] CFG_IDX = 6'h19;
   localparam logic [5:0] AUX_IDX = 6'h1A;
   localparam logic [5:0] PROT_IDX = 6'h1B;
   localparam logic [5:0] CTRL_IDX = 6'h1E;
   localparam logic [5:0] HANG_IDX = 6'h20;
   localparam logic [5:0] WARN_IDX = 6'h26;
   localparam logic [5:0] STA_IDX = 6'h27;
   localparam logic [5:0] TURNS_IDX = 6'h28;

   // Field positions
   localparam int RES_LSB = 0;
   localparam int IDXW_LSB = 4;
   localparam int INV_BIT = 6;
   localparam int UVW_BIT = 7;
   localparam int RO_BIT = 8;
   localparam int ROUTE_BIT = 12;
   localparam int SLEW_LSB = 0;
   localparam int HYST_LSB = 8;
   localparam int T45_BIT = 14;
   localparam int LOCK_BIT = 0;
   localparam int SLDIS_BIT = 3;
   localparam int TW_BIT = 0;
   localparam int SRW_BIT = 1;

   // Reset values
   localparam logic [15:0] CFG_RST = 16'h0003;
   localparam logic [15:0] AUX_RST = 16'h0000;
   localparam logic [15:0] PROT_RST = 16'h0000;
   localparam logic [7:0] TURNS_RST_CMD = 8'h01;

   // Angle and resolution
   localparam int ANG_W = 14;
   localparam logic [3:0] RES_MIN = 4'h3;
   localparam logic [3:0] RES_MAX = 4'hE;

   // Turns counter limits
   localparam logic signed [11:0] T45_HI = 12'sd2047;
   localparam logic signed [11:0] T45_LO = 12'sh800;
   localparam logic signed [11:0] T180_HI = 12'sd511;
   localparam logic signed [11:0] T180_LO = -12'sd512;

   // Timing: slew interval unit, rounded up to whole cycles
   localparam int CLK_NS = 8;
   localparam int SLEW_TICK_NS = 100;
   localparam int SLEW_TICK_CYC = (SLEW_TICK_NS + CLK_NS - 1) / CLK_NS;

   typedef struct packed {
      logic route;
      logic [5:0] hyst;
      logic t45;
      logic [7:0] slew;
      logic ro;
      logic commutation_outputs;
      logic inv;
      logic [1:0] idxw;
      logic [3:0] res;
   } aeo_cfg_t;
endpackage
`default_nettype wire

// [testbench/aeo_quad_rx.sv]
`default_nettype none
module aeo_quad_rx (
   input wire logic clk,
   input wire logic rst,
   input wire logic a,
   input wire logic b,
   output int pos,
   output int bad,
   output int gap
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] prev;
   int since;
   // Next code upward in the 00, 01, 11, 10 cycle
   function automatic logic [1:0] up(input logic [1:0] s);
      return {s[0], ~s[1]};
   endfunction
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prev <= 2'b00;
         pos <= 0;
         bad <= 0;
         gap <= 0;
         since <= 0;
      end else begin
         since <= since + 1;
         if ({a, b} != prev) begin
            prev <= {a, b};
            gap <= since + 1;
            since <= 0;
            if ({a, b} == up(prev)) begin
               pos <= pos + 1;
            end else if (prev == up({a, b})) begin
               pos <= pos - 1;
            end else begin
               // Both lines moved: direction is lost
               bad <= bad + 1;
            end
         end
      end
   end
endmodule // aeo_quad_rx
`default_nettype wire

// [testbench/angle_encoder_outputs_bench.sv]
`default_nettype none
module angle_encoder_outputs_bench import aeo_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, ce, rd, wr, av, stv, zv, slw;
   logic [7:0] adr;
   logic [31:0] wd, rdat;
   logic [13:0] ang;
   logic [2:0] oct;
   logic [5:0] sli;
   logic [15:0] sld;
   wire logic [31:0] avrd;
   wire logic wrq, qa, qb, qi, cu, cv, cw;
   int error_cnt, tests_run, pos, bad, gap;
   aeo_encoder_out u_dut (
      .clk(clk), .rst(rst), .ce(ce), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_readdata(avrd), .avs_waitrequest(wrq),
      .ang_valid(av), .ang_value(ang), .self_test_done(stv), .zcd_valid(zv),
      .zcd_octant(oct), .sl_write(slw), .sl_index(sli), .sl_data(sld),
      .quad_a(qa), .quad_b(qb), .quad_index(qi), .comm_u(cu), .comm_v(cv), .comm_w(cw)
   );
   aeo_quad_rx u_rx (.clk(clk), .rst(rst), .a(qa), .b(qb), .pos(pos), .bad(bad), .gap(gap));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic results;
      $display("errors %0d, checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [5:0] i, input logic [15:0] d);
      int n;
      n = 0;
      adr <= {i, 2'b00};
      wd <= {16'h0000, d};
      wr <= w;
      rd <= ~w;
      @(posedge clk);
      while (wrq !== 1'b0) begin
         n++;
         if (n > 20) begin
            error_cnt++;
            results();
         end
         @(posedge clk);
      end
      rdat = avrd;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [5:0] i, input logic [15:0] e, input string m);
      bus(1'b0, i, 16'h0000);
      check(rdat, {16'h0000, e}, m);
   endtask
   task automatic put(input logic [13:0] v);
      ang <= v;
      av <= 1'b1;
      @(posedge clk);
      av <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic step(input logic [2:0] o);
      oct <= o;
      zv <= 1'b1;
      @(posedge clk);
      zv <= 1'b0;
      @(posedge clk);
   endtask
   task automatic sl_put(input logic [15:0] d);
      sli <= CFG_IDX;
      sld <= d;
      slw <= 1'b1;
      @(posedge clk);
      slw <= 1'b0;
      @(posedge clk);
   endtask
   task automatic self_test;
      stv <= 1'b1;
      @(posedge clk);
      stv <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_reset;
      rchk(CFG_IDX, CFG_RST, "cfg reset");
      rchk(AUX_IDX, AUX_RST, "aux reset");
      rchk(PROT_IDX, PROT_RST, "prot reset");
      rchk(STA_IDX, 16'h0000, "head reset");
      rchk(6'h3F, 16'h0000, "unmapped read");
   endtask
   task automatic t_quad;
      logic [1:0] s;
      sl_put(16'h000E);
      rchk(CFG_IDX, 16'h000E, "supply-line write");
      for (int i = 0; i < 5; i++) begin
         s = i[1:0];
         put({s, 12'h000});
         check({qa, qb}, {s[1], s[1] ^ s[0]}, "quad state");
         if (i > 0) check(qi, s == 2'b00, "index");
      end
      put(14'h3000);
      check(pos, 3, "rx down step");
      put(14'h0000);
      check(bad, 0, "rx legal");
   endtask
   task automatic t_slew;
      int p0;
      p0 = pos;
      bus(1'b1, CFG_IDX, 16'h000D);
      bus(1'b1, AUX_IDX, 16'h0001);
      put(14'd6144);
      repeat (60) @(posedge clk);
      check(pos, p0 + 3, "skipped states");
      check(bad, 0, "slew legal");
      check(gap, 14, "slew interval");
      rchk(WARN_IDX, 16'h0002, "slew warning");
      bus(1'b1, WARN_IDX, 16'h0002);
      rchk(WARN_IDX, 16'h0000, "slew cleared");
   endtask
   task automatic t_turns;
      step(3'd0);
      for (int i = 1; i <= 2080; i++) step(i[2:0]);
      rchk(TURNS_IDX, 16'h01FF, "turns limit");
      rchk(WARN_IDX, 16'h0001, "turns warning");
      bus(1'b1, CTRL_IDX, {8'h00, TURNS_RST_CMD});
      rchk(TURNS_IDX, 16'h0000, "turns zeroed");
      rchk(WARN_IDX, 16'h0000, "warning cleared");
      for (int i = 1; i <= 4; i++) step(i[2:0]);
      rchk(TURNS_IDX, 16'h0001, "half turn");
      bus(1'b1, AUX_IDX, 16'h4000);
      for (int i = 3; i >= 1; i--) step(i[2:0]);
      rchk(TURNS_IDX, 16'h0FFE, "octant steps");
   endtask
   task automatic t_hyst;
      bus(1'b1, AUX_IDX, 16'h0800);
      self_test();
      put(14'd1000);
      rchk(HANG_IDX, 16'd250, "hyst load");
      put(14'd992);
      rchk(HANG_IDX, 16'd250, "hyst edge holds");
      rchk(STA_IDX, 16'h0000, "head up");
      put(14'd980);
      rchk(HANG_IDX, 16'd245, "hyst exit");
      rchk(STA_IDX, 16'h0001, "head down");
      self_test();
      rchk(STA_IDX, 16'h0000, "head self test");
   endtask
   task automatic t_route;
      bus(1'b1, CFG_IDX, 16'h002D);
      put(14'd6144);
      check(qi, 1'b0, "index width end");
      put(14'd4096);
      check(qi, 1'b1, "index width held");
      bus(1'b1, CFG_IDX, 16'h006D);
      put(14'd4096);
      check({qa, qb, qi}, 3'b000, "abi invert");
      bus(1'b1, CFG_IDX, 16'h012D);
      put(14'd4096);
      check({qa, qb, qi}, 3'b110, "rotation order");
      bus(1'b1, CFG_IDX, 16'h102D);
      put(14'd12286);
      put(14'd12292);
      check({qa, qb, qi}, 3'b010, "route holds");
      rchk(HANG_IDX, 16'h0BFF, "route readback");
   endtask
   task automatic t_uvw;
      logic [15:0] c [8] = '{16'h0080, 16'h0080, 16'h0080, 16'h0080,
                             16'h0080, 16'h0080, 16'h0081, 16'h00C0};
      logic [13:0] a [8] = '{14'd1365, 14'd4096, 14'd6827, 14'd9557,
                             14'd12288, 14'd15019, 14'd2048, 14'd1365};
      logic [2:0] e [8] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h4, 3'h2};
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, CFG_IDX, c[i]);
         put(a[i]);
         check({cu, cv, cw}, e[i], "commutation");
      end
   endtask
   task automatic t_lock;
      bus(1'b1, PROT_IDX, 16'h0008);
      sl_put(16'h0005);
      rchk(CFG_IDX, 16'h00C0, "supply-line off");
      bus(1'b1, PROT_IDX, 16'h0009);
      bus(1'b1, CFG_IDX, 16'h0003);
      rchk(CFG_IDX, 16'h00C0, "cfg locked");
      bus(1'b1, PROT_IDX, 16'h0000);
      rchk(PROT_IDX, 16'h0009, "lock sticky");
   endtask
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      {rd, wr, av, stv, zv, slw} = 6'h00;
      adr = 8'h00;
      wd = 32'h0000_0000;
      ang = 14'h0000;
      oct = 3'h0;
      sli = 6'h00;
      sld = 16'h0000;
      error_cnt = 0;
      tests_run = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_quad();
      t_slew();
      t_turns();
      t_hyst();
      t_route();
      t_uvw();
      t_lock();
      results();
   end
endmodule // angle_encoder_outputs_bench
`default_nettype wire
